//--- bench/cmd_source_model.sv
// partner model: the command sources that offer words to the decoder
`timescale 1ns/10ps
`default_nettype none
module cmd_source_model (
  ref_clk,
  cmd_in
);
  input wire logic ref_clk; // system clock
  output var cmd_word_pkg::cmd_in_type cmd_in; // offer towards the decoder
  bit strict = 1'b1; // high: reserved control bits written as zero
  initial cmd_in = '0;
  // =====================================================
  // offer one word for one cycle, then stop holding it
  task automatic offer(input logic [2:0] src, input logic [15:0] w);
    logic [15:0] v;
    v = strict ? (w & 16'hF98F) : w;
    @(posedge ref_clk);
    cmd_in <= '{valid: 1'b1, source: src, word: v};
    @(posedge ref_clk);
    cmd_in.valid <= 1'b0;
    cmd_in.word <= ~v; // released word no longer shows its value
  endtask : offer
endmodule : cmd_source_model
`default_nettype wire

//--- bench/drive_control_word_decoder_tb_top.sv
// testbench: self-checking bench of the command word decoder
`timescale 1ns/10ps
`default_nettype none
module drive_control_word_decoder_tb_top;
  localparam logic [21:0] CIA = 22'h3FFFFF; // every output, forward run must stay low
  localparam logic [21:0] IO = 22'h3FFFFF; // every output, cia402 levels must stay low
  typedef struct {
    logic [1:0] prof;
    logic [15:0] word;
    logic [21:0] exp;
    logic [21:0] mask;
  } row_type;
  logic ref_clk = 1'b0; // 20 MHz clock
  logic resetn = 1'b0; // async reset, active low
  logic clk_en = 1'b1; // clock enable
  logic canopen_fitted = 1'b0; // option strap
  logic fieldbus_fitted = 1'b0; // option strap
  logic [3:0] reg_addr = 4'h0; // register address
  logic [15:0] reg_wdata = 16'h0000; // write data
  logic reg_wr = 1'b0; // write strobe
  logic reg_rd = 1'b0; // read strobe
  logic [15:0] reg_rdata; // read data
  logic [1:0] halt_stop_style; // stop style for halt
  cmd_word_pkg::cmd_in_type cmd_in; // offer from the partner
  cmd_word_pkg::cmd_out_type cmd_out; // decoded requests
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  row_type rows[12] = '{
    '{2'h0, 16'h000F, 22'h340000, CIA}, '{2'h0, 16'h0000, 22'h080000, CIA},
    '{2'h0, 16'hF806, 22'h107C00, CIA}, '{2'h0, 16'h0108, 22'h0D0000, CIA},
    '{2'h1, 16'h0001, 22'h008000, IO}, '{2'h1, 16'hAAAA, 22'h005555, IO},
    '{2'h2, 16'h0001, 22'h000000, IO}, '{2'h2, 16'h0003, 22'h008000, IO},
    '{2'h2, 16'h0001, 22'h008000, IO}, '{2'h2, 16'h0000, 22'h000000, IO},
    '{2'h2, 16'h0002, 22'h000000, IO}, '{2'h2, 16'h0003, 22'h000000, IO}};
  // =====================================================
  // clock, partner and design
  always #25 ref_clk = ~ref_clk;
  cmd_source_model model (.ref_clk(ref_clk), .cmd_in(cmd_in));
  drive_control_word_decoder DUT (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
    .cmd_in(cmd_in), .canopen_fitted(canopen_fitted), .fieldbus_fitted(fieldbus_fitted),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd_out(cmd_out), .halt_stop_style(halt_stop_style));
  // =====================================================
  // tasks
  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  task automatic check_out(input string n, input logic [21:0] e, input logic [21:0] m);
    logic [21:0] s;
    s = cmd_out;
    checks_done++;
    if ((s & m) !== (e & m)) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e & m, s & m);
    end
  endtask : check_out
  task automatic check_reg(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : check_reg
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input string n, input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check_reg(n, reg_rdata, e);
  endtask : reg_read
  // offer a word, then stop where the decoded outputs have just landed
  task automatic apply(input logic [2:0] src, input logic [15:0] w);
    model.offer(src, w);
    @(posedge ref_clk);
    #1;
  endtask : apply
  // =====================================================
  // timeout watchdog
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  // =====================================================
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    #1 check_out("reset_out", 22'h0, 22'h3FFFFF);
    reg_read("source_rst", cmd_word_pkg::ADDR_SOURCE_SEL, 16'h0000);
    reg_read("profile_rst", cmd_word_pkg::ADDR_PROFILE, 16'h0000);
    reg_write(cmd_word_pkg::ADDR_ASSIGN_MAP, 16'hFFFF);
    // table of ordinary words in each profile
    foreach (rows[i]) begin
      model.strict = (rows[i].prof == 2'h0);
      reg_write(cmd_word_pkg::ADDR_PROFILE, {12'h002, 2'b00, rows[i].prof});
      apply(3'h0, rows[i].word);
      check_out("row_out", rows[i].exp, rows[i].mask);
    end
    check_reg("stop_style", {14'h0, halt_stop_style}, 16'h0002);
    // fault reset: one pulse on the rise, none on a static level
    model.strict = 1'b1;
    reg_write(cmd_word_pkg::ADDR_PROFILE, 16'h0020);
    apply(3'h0, 16'h0080);
    check_out("fault_rise", 22'h0A0000, CIA);
    @(posedge ref_clk);
    #1 check_out("fault_pulse", 22'h080000, CIA);
    apply(3'h0, 16'h0080);
    check_out("fault_level", 22'h080000, CIA);
    // reserved bits set by a careless controller are ignored
    model.strict = 1'b0;
    apply(3'h0, 16'h0670);
    check_out("reserved", 22'h080000, CIA);
    model.strict = 1'b1;
    // word from a source that is not selected
    apply(3'h2, 16'h000F);
    check_out("other_src", 22'h080000, CIA);
    // low clock enable: a selected word is not taken, outputs frozen
    @(posedge ref_clk);
    clk_en <= 1'b0;
    apply(3'h0, 16'h000F);
    check_out("frozen", 22'h080000, CIA);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    @(posedge ref_clk);
    #1 check_out("thawed", 22'h080000, CIA);
    // option source chosen without its module
    reg_write(cmd_word_pkg::ADDR_SOURCE_SEL, 16'h0003);
    reg_read("unfitted", cmd_word_pkg::ADDR_STATUS, 16'h0000);
    canopen_fitted <= 1'b1;
    fieldbus_fitted <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // every source code in turn
    for (int s = 0; s < 6; s++) begin
      reg_write(cmd_word_pkg::ADDR_SOURCE_SEL, 16'(s));
      apply(3'(s), 16'h1801 + 16'(s));
      reg_read("image", cmd_word_pkg::ADDR_WORD_IMAGE, 16'h1801 + 16'(s));
    end
    reg_read("status", cmd_word_pkg::ADDR_STATUS, 16'h000F);
    reg_write(cmd_word_pkg::ADDR_WORD_IMAGE, 16'h1234);
    reg_read("image_ro", cmd_word_pkg::ADDR_WORD_IMAGE, 16'h1806);
    reg_read("unmapped", 4'hF, 16'h0000);
    reg_write(cmd_word_pkg::ADDR_SOURCE_SEL, 16'h0006);
    reg_read("bad_code", cmd_word_pkg::ADDR_STATUS, 16'h000C);
    // second reset in mid-run
    @(posedge ref_clk);
    resetn <= 1'b0;
    @(posedge ref_clk);
    #1 check_out("reset_again", 22'h0, 22'h3FFFFF);
    @(posedge ref_clk);
    resetn <= 1'b1;
    reg_read("source_again", cmd_word_pkg::ADDR_SOURCE_SEL, 16'h0000);
    finish_test();
  end
endmodule : drive_control_word_decoder_tb_top
`default_nettype wire

//--- logic/cmd_edge_detect.sv
// module: rising edge pulses for edge-sensitive command bits
`timescale 1ns/10ps
`default_nettype none
module cmd_edge_detect #(
  parameter int WIDTH = 2
) (
  ref_clk,
  resetn,
  clk_en,
  level_in,
  rise_out
);
  input wire logic ref_clk;
  input wire logic resetn;
  input wire logic clk_en;
  input wire logic [WIDTH-1:0] level_in;
  output logic [WIDTH-1:0] rise_out;

  logic [WIDTH-1:0] prev_r; // last sampled levels

  // =====================================================
  // previous value register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev_r <= '0;
    end else if (clk_en) begin
      prev_r <= level_in; // R17
    end
  end

  // one pulse per 0 to 1 transition
  assign rise_out = level_in & ~prev_r & {WIDTH{clk_en}}; // R17
endmodule : cmd_edge_detect
`default_nettype wire

//--- logic/cmd_source_select.sv
// module: picks the command word of the selected source
`timescale 1ns/10ps
`default_nettype none
module cmd_source_select (
  ref_clk,
  resetn,
  clk_en,
  cmd_in,
  source_sel,
  canopen_fitted,
  fieldbus_fitted,
  word_valid,
  word_value,
  source_ok
);
  input wire logic ref_clk;
  input wire logic resetn;
  input wire logic clk_en;
  input wire cmd_word_pkg::cmd_in_type cmd_in;
  input wire logic [2:0] source_sel;
  input wire logic canopen_fitted;
  input wire logic fieldbus_fitted;
  output logic word_valid;
  output logic [15:0] word_value;
  output logic source_ok;

  // =====================================================
  // selection legality
  wire sel_is_can = (source_sel == cmd_word_pkg::SRC_CANOPEN);
  wire sel_is_fb = (source_sel == cmd_word_pkg::SRC_FIELDBUS);
  wire sel_in_range = (source_sel <= cmd_word_pkg::SRC_ETHERNET);
  // option modules only count when fitted
  assign source_ok = sel_in_range && !(sel_is_can && !canopen_fitted)
    && !(sel_is_fb && !fieldbus_fitted); // R1
  // only the selected source is taken
  wire take = cmd_in.valid && source_ok && (cmd_in.source == source_sel); // R13

  // =====================================================
  // latched word of the active source
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      word_valid <= 1'b0;
      word_value <= 16'h0000;
    end else if (clk_en) begin
      // an illegal or unfitted source drops the old word
      if (!source_ok) begin
        word_valid <= 1'b0; // R1
      end else if (take) begin
        word_valid <= 1'b1; // R18
        word_value <= cmd_in.word; // R13
      end
    end
  end
endmodule : cmd_source_select
`default_nettype wire

//--- logic/cmd_word_pkg.sv
// package: constants and types shared by the command word decoder
package cmd_word_pkg;

  // =====================================================
  // register map
  localparam logic [3:0] ADDR_SOURCE_SEL = 4'h0;
  localparam logic [3:0] ADDR_PROFILE = 4'h1;
  localparam logic [3:0] ADDR_WORD_IMAGE = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_ASSIGN_MAP = 4'h4;

  // =====================================================
  // field positions
  localparam int BIT_SWITCH_ON = 0;
  localparam int BIT_ENABLE_VOLTAGE = 1;
  localparam int BIT_QUICK_STOP_N = 2;
  localparam int BIT_ENABLE_OP = 3;
  localparam int BIT_FAULT_RESET = 7;
  localparam int BIT_HALT = 8;
  localparam int BIT_IO_FWD = 0;
  localparam int BIT_IO_RUN_AUTH = 0;
  localparam int BIT_IO_FWD_EDGE = 1;

  // =====================================================
  // reset values
  localparam logic [2:0] SOURCE_RESET = 3'h0;
  localparam logic [1:0] PROFILE_RESET = 2'h0;
  localparam logic [15:0] ASSIGN_RESET = 16'h0000;

  // =====================================================
  // command sources
  typedef enum logic [2:0] {
    SRC_TERMINAL = 3'b000,
    SRC_DISPLAY = 3'b001,
    SRC_MODBUS = 3'b010,
    SRC_CANOPEN = 3'b011,
    SRC_FIELDBUS = 3'b100,
    SRC_ETHERNET = 3'b101
  } source_type;

  // control profiles
  typedef enum logic [1:0] {
    PROF_CIA402 = 2'b00,
    PROF_IO_2WIRE = 2'b01,
    PROF_IO_3WIRE = 2'b10
  } profile_type;

  // incoming word with its source tag
  typedef struct packed {
    logic valid;
    logic [2:0] source;
    logic [15:0] word;
  } cmd_in_type;

  // decoded command requests
  typedef struct packed {
    logic switch_on;
    logic voltage_enable;
    logic quick_stop;
    logic run;
    logic fault_reset;
    logic halt;
    logic fwd_run;
    logic [14:0] assignable;
  } cmd_out_type;

endpackage : cmd_word_pkg

//--- logic/drive_control_word_decoder.sv
// module: decoder of the drive command word into run requests
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1: one selected source; option sources need module
// R2: CiA402 decoding unless I/O profile chosen
// R3: bit 0 high requests switch on
// R4: bit 1 low disables voltage
// R5: bit 2 low requests quick stop
// R6: bit 3 high requests run
// R7: bits 4 to 6 reserved, ignored
// R8: fault reset only on bit 7 rise
// R9: bit 8 high halts, stays enabled
// R10: bits 9-10 reserved; 11-15 assignable
// R11: 2-wire: bit 0 level is forward run
// R12: I/O bit 0 function is fixed
// R13: act only on words of selected source
// R14: 2-wire: bits 1-15 assignable
// R15: 3-wire: bit 0 authorises run
// R16: 3-wire: forward starts on bit 1 rise
// R17: edges detected as one-cycle pulses
// R18: reset selects terminals, outputs inactive
module drive_control_word_decoder (
  ref_clk,
  resetn,
  clk_en,
  cmd_in,
  canopen_fitted,
  fieldbus_fitted,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  cmd_out,
  halt_stop_style
);
  input wire logic ref_clk; // 20 MHz system clock
  input wire logic resetn; // async reset, active low
  input wire logic clk_en; // freezes all state when low
  input wire cmd_word_pkg::cmd_in_type cmd_in; // word from a source
  input wire logic canopen_fitted; // option module strap
  input wire logic fieldbus_fitted; // option module strap
  input wire logic [3:0] reg_addr; // register address
  input wire logic [15:0] reg_wdata; // write data
  input wire logic reg_wr; // write strobe
  input wire logic reg_rd; // read strobe
  output logic [15:0] reg_rdata; // read data, one cycle later
  output cmd_word_pkg::cmd_out_type cmd_out; // decoded requests
  output logic [1:0] halt_stop_style; // configured stop style for halt

  // =====================================================
  // strap synchronisers (pins)
  logic [1:0] fit_meta_r; // first stage
  logic [1:0] fit_sync_r; // second stage

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fit_meta_r <= 2'h0;
      fit_sync_r <= 2'h0;
    end else if (clk_en) begin
      fit_meta_r <= {fieldbus_fitted, canopen_fitted};
      fit_sync_r <= fit_meta_r;
    end
  end

  // =====================================================
  // configuration registers
  logic [2:0] source_sel_r; // selected command source
  logic [1:0] profile_r; // control profile
  logic [1:0] stop_style_r; // halt stop style
  logic [15:0] assign_map_r; // enables for assignable bits
  logic [15:0] rdata_r; // read data holding
  logic [15:0] rdata_nxt; // read data next

  // address decode
  wire wr_source = reg_wr && (reg_addr == cmd_word_pkg::ADDR_SOURCE_SEL);
  wire wr_profile = reg_wr && (reg_addr == cmd_word_pkg::ADDR_PROFILE);
  wire wr_assign = reg_wr && (reg_addr == cmd_word_pkg::ADDR_ASSIGN_MAP);

  // register writes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      source_sel_r <= cmd_word_pkg::SOURCE_RESET; // R18
      profile_r <= cmd_word_pkg::PROFILE_RESET;
      stop_style_r <= 2'h0;
      assign_map_r <= cmd_word_pkg::ASSIGN_RESET;
    end else if (clk_en) begin
      if (wr_source) begin
        source_sel_r <= reg_wdata[2:0]; // R1
      end
      if (wr_profile) begin
        profile_r <= reg_wdata[1:0];
        stop_style_r <= reg_wdata[5:4];
      end
      if (wr_assign) begin
        assign_map_r <= reg_wdata; // bit 0 stored, but only bits 15:1 are used below
      end
    end
  end

  // =====================================================
  // source selection
  logic word_valid; // a word from the source is present
  logic [15:0] word_value; // that word
  logic source_ok; // selection legal and fitted

  cmd_source_select u_select (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .cmd_in(cmd_in),
    .source_sel(source_sel_r),
    .canopen_fitted(fit_sync_r[0]),
    .fieldbus_fitted(fit_sync_r[1]),
    .word_valid(word_valid),
    .word_value(word_value),
    .source_ok(source_ok)
  );

  // =====================================================
  // edge detection on fault reset and 3-wire forward
  wire [1:0] edge_levels = {word_value[cmd_word_pkg::BIT_IO_FWD_EDGE] & word_valid,
    word_value[cmd_word_pkg::BIT_FAULT_RESET] & word_valid};
  logic [1:0] edge_rise; // one-cycle rising pulses

  cmd_edge_detect #(
    .WIDTH(2)
  ) u_edges (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .level_in(edge_levels),
    .rise_out(edge_rise)
  );

  // =====================================================
  // profile decode
  wire is_cia = (profile_r != cmd_word_pkg::PROF_IO_2WIRE)
    && (profile_r != cmd_word_pkg::PROF_IO_3WIRE); // R2
  wire is_2wire = (profile_r == cmd_word_pkg::PROF_IO_2WIRE);
  wire is_3wire = (profile_r == cmd_word_pkg::PROF_IO_3WIRE);
  wire live = word_valid; // R13

  // cia402 fields, bits 4-6 and 9-10 never read
  wire cia_switch_on = live && word_value[cmd_word_pkg::BIT_SWITCH_ON]; // R3
  wire cia_volt_en = live && word_value[cmd_word_pkg::BIT_ENABLE_VOLTAGE]; // R4
  wire cia_quick = live && !word_value[cmd_word_pkg::BIT_QUICK_STOP_N]; // R5
  wire cia_run = live && word_value[cmd_word_pkg::BIT_ENABLE_OP]; // R6
  wire cia_halt = live && word_value[cmd_word_pkg::BIT_HALT]; // R9
  wire [14:0] cia_assign = {word_value[15:11], 10'h000} & assign_map_r[15:1]; // R10 R7

  // 2-wire: fixed forward level on bit 0
  wire w2_fwd = live && word_value[cmd_word_pkg::BIT_IO_FWD]; // R11 R12
  wire [14:0] w2_assign = word_value[15:1] & assign_map_r[15:1]; // R14

  // 3-wire: run authorisation and forward edge
  wire w3_auth = live && word_value[cmd_word_pkg::BIT_IO_RUN_AUTH]; // R15
  logic w3_run_r; // latched forward run in 3-wire
  logic w3_run_nxt;
  assign w3_run_nxt = !(is_3wire && w3_auth) ? 1'b0 : (edge_rise[1] ? 1'b1 : w3_run_r); // R15 R16
  wire [14:0] w3_assign = {word_value[15:2], 1'b0} & assign_map_r[15:1];

  // =====================================================
  // output selection
  wire cmd_word_pkg::cmd_out_type out_nxt; // next value of the output register
  assign out_nxt.switch_on = is_cia && cia_switch_on;
  assign out_nxt.voltage_enable = is_cia && cia_volt_en;
  assign out_nxt.quick_stop = is_cia && cia_quick;
  assign out_nxt.run = is_cia && cia_run;
  assign out_nxt.fault_reset = is_cia && edge_rise[0]; // R8
  assign out_nxt.halt = is_cia && cia_halt;
  assign out_nxt.fwd_run = is_2wire ? w2_fwd : (is_3wire ? w3_run_nxt : 1'b0);
  assign out_nxt.assignable = is_cia ? cia_assign : (is_2wire ? w2_assign : w3_assign);

  // read mux
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        cmd_word_pkg::ADDR_SOURCE_SEL: rdata_nxt = {13'h0000, source_sel_r};
        cmd_word_pkg::ADDR_PROFILE: rdata_nxt = {10'h000, stop_style_r, 2'h0, profile_r};
        cmd_word_pkg::ADDR_WORD_IMAGE: rdata_nxt = word_value;
        cmd_word_pkg::ADDR_STATUS: rdata_nxt = {12'h000, fit_sync_r, source_ok, word_valid};
        cmd_word_pkg::ADDR_ASSIGN_MAP: rdata_nxt = assign_map_r;
        default: rdata_nxt = 16'h0000; // unmapped reads zero
      endcase
    end
  end

  // =====================================================
  // output registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_out <= '0; // R18
      w3_run_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else if (clk_en) begin
      cmd_out <= out_nxt;
      w3_run_r <= w3_run_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata = rdata_r;

  // stop style follows its register directly
  assign halt_stop_style = stop_style_r; // R9

  // =====================================================
  // assertions
  chk_fault_pulse_once: assert property (@(posedge ref_clk) disable iff (!resetn) // R8
    clk_en && cmd_out.fault_reset |=> !cmd_out.fault_reset || !clk_en)
    else $error("fault reset pulse longer than one cycle");
  chk_reset_inactive: assert property (@(posedge ref_clk) disable iff (!resetn) // R18
    !word_valid && clk_en |=> !cmd_out.run && !cmd_out.switch_on)
    else $error("command active without a word");
  chk_io_no_cia: assert property (@(posedge ref_clk) disable iff (!resetn) // R2
    !is_cia && clk_en |=> !cmd_out.run && !cmd_out.halt)
    else $error("cia402 output in io profile");
  chk_switch_on_bit: assert property (@(posedge ref_clk) disable iff (!resetn) // R3
    clk_en && is_cia && live |=> cmd_out.switch_on == $past(word_value[0]))
    else $error("switch on does not follow bit 0");
  chk_quick_stop_bit: assert property (@(posedge ref_clk) disable iff (!resetn) // R5
    clk_en && is_cia && live |=> cmd_out.quick_stop == !$past(word_value[2]))
    else $error("quick stop does not follow bit 2");
  chk_two_wire_fwd: assert property (@(posedge ref_clk) disable iff (!resetn) // R11
    clk_en && is_2wire |=> cmd_out.fwd_run == $past(w2_fwd))
    else $error("2-wire forward wrong");
  chk_three_wire_auth: assert property (@(posedge ref_clk) disable iff (!resetn) // R15
    clk_en && is_3wire && !w3_auth |=> !cmd_out.fwd_run)
    else $error("3-wire run without authorisation");
  chk_source_gate: assert property (@(posedge ref_clk) disable iff (!resetn) // R1
    clk_en && !source_ok |=> !word_valid)
    else $error("word kept from illegal source");
  cov_fault_reset: cover property (@(posedge ref_clk) disable iff (!resetn) cmd_out.fault_reset);
  cov_three_wire_run: cover property (@(posedge ref_clk) disable iff (!resetn)
    is_3wire && cmd_out.fwd_run);
  cov_cia_run: cover property (@(posedge ref_clk) disable iff (!resetn) cmd_out.run);

  // =====================================================
  // further checks on the cia402 fields
  // voltage permission follows bit 1 one cycle later
  chk_voltage_bit: assert property (@(posedge ref_clk) disable iff (!resetn) // R4
    clk_en && is_cia && live |=> cmd_out.voltage_enable == $past(word_value[1]))
    else $error("voltage enable does not follow bit 1");
  // run request follows bit 3
  chk_run_bit: assert property (@(posedge ref_clk) disable iff (!resetn) // R6
    clk_en && is_cia && live |=> cmd_out.run == $past(word_value[3]))
    else $error("run does not follow bit 3");
  // halt follows bit 8 as a level
  chk_halt_bit: assert property (@(posedge ref_clk) disable iff (!resetn) // R9
    clk_en && is_cia && live |=> cmd_out.halt == $past(word_value[8]))
    else $error("halt does not follow bit 8");
  // reserved and low word bits never reach the assignable outputs
  chk_cia_reserved: assert property (@(posedge ref_clk) disable iff (!resetn) // R10 R7
    clk_en && is_cia |=> cmd_out.assignable[9:0] == 10'h000)
    else $error("reserved bit passed in cia402 profile");
  // a held fault reset level gives no new pulse
  chk_fault_static: assert property (@(posedge ref_clk) disable iff (!resetn) // R8
    clk_en && $past(clk_en) && is_cia && edge_levels[0] && $past(edge_levels[0])
    |=> !cmd_out.fault_reset)
    else $error("fault reset on a static level");
  // cia402 profile never shows the io forward run
  chk_cia_no_fwd: assert property (@(posedge ref_clk) disable iff (!resetn) // R2
    clk_en && is_cia |=> !cmd_out.fwd_run)
    else $error("forward run in cia402 profile");
  // io profiles keep the cia402 levels off
  chk_io_levels_off: assert property (@(posedge ref_clk) disable iff (!resetn) // R2
    !is_cia && clk_en |=> !cmd_out.switch_on && !cmd_out.voltage_enable && !cmd_out.quick_stop)
    else $error("cia402 level in io profile");

  // =====================================================
  // checks on edges, sources and the bus
  // edge pulses last one enabled cycle
  chk_edge_single: assert property (@(posedge ref_clk) disable iff (!resetn) // R17
    clk_en && edge_rise[0] |=> !edge_rise[0])
    else $error("fault edge pulse repeated");
  chk_fwd_edge_single: assert property (@(posedge ref_clk) disable iff (!resetn) // R17
    clk_en && edge_rise[1] |=> !edge_rise[1])
    else $error("forward edge pulse repeated");
  // 3-wire: authorised rise starts forward run
  chk_three_wire_start: assert property (@(posedge ref_clk) disable iff (!resetn) // R16
    clk_en && is_3wire && w3_auth && edge_rise[1] |=> cmd_out.fwd_run)
    else $error("3-wire forward did not start on rise");
  // 3-wire: running state holds while authorised
  chk_three_wire_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // R15
    clk_en && is_3wire && w3_auth && w3_run_r |=> cmd_out.fwd_run)
    else $error("3-wire forward dropped while authorised");
  // a word of another source leaves the latched word alone
  chk_other_source: assert property (@(posedge ref_clk) disable iff (!resetn) // R13
    clk_en && cmd_in.valid && (cmd_in.source != source_sel_r) |=> $stable(word_value))
    else $error("word taken from a source not selected");
  // a word of the selected legal source is latched
  chk_word_taken: assert property (@(posedge ref_clk) disable iff (!resetn) // R13
    clk_en && cmd_in.valid && source_ok && (cmd_in.source == source_sel_r)
    |=> word_valid && word_value == $past(cmd_in.word))
    else $error("selected word not latched");
  // read data stand only in the cycle after a read
  chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (!resetn) // R1
    clk_en && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data present without a read");
  // low clock enable freezes the outputs
  chk_freeze_outputs: assert property (@(posedge ref_clk) disable iff (!resetn) // R17
    !clk_en |=> $stable(cmd_out))
    else $error("outputs moved while clock enable low");
  cov_two_wire_fwd: cover property (@(posedge ref_clk) disable iff (!resetn)
    is_2wire && cmd_out.fwd_run);
  cov_frozen: cover property (@(posedge ref_clk) disable iff (!resetn)
    !clk_en && cmd_in.valid);
endmodule : drive_control_word_decoder
`default_nettype wire
